// [core/mcr_misc_config.sv]
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
// Purpose: miscellaneous configuration register with external interrupts
// Assumes: 100 MHz clock, one-cycle strobes, read data one cycle later
// Notes:   sensitivity fields only change while the cpu mask flag is set
module mcr_misc_config
  import mcr_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // cpu mask flag
  input  wire logic       cpu_irq_masked_i,
  // external pins
  input  wire logic       porta_ext_irq_i,
  input  wire logic       portb_ext_irq_i,
  input  wire logic       ss_pin_i,
  // configuration outputs
  output logic      [5:0] periph_clock_div_o,
  output logic      [5:0] cpu_clock_div_o,
  output logic            spi_ss_level_o,
  output logic            porta_ext_irq_o,
  output logic            portb_ext_irq_o,
  output logic            irq_o
);

  typedef struct packed {
    logic [7:0] cfg;
    logic [1:0] stat;
    logic [1:0] en;
    logic [7:0] rdata;
    logic [2:0] ss_sync;
    logic       ss_level;
    logic [5:0] pdiv;
    logic [5:0] cdiv;
    logic       ss_out;
    logic       reqa;
    logic       reqb;
    logic       irq;
  } mcr_state_t;

  mcr_state_t st;
  mcr_state_t next_st;

  mcr_edge_if ifa ();
  mcr_edge_if ifb ();

  // sense fields straight from the stored register
  assign ifa.sense = st.cfg[MCR_BIT_PORTA_SENSE +: 2];
  assign ifb.sense = st.cfg[MCR_BIT_PORTB_SENSE +: 2];

  mcr_edge_det u_det_a (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (porta_ext_irq_i),
    .ev        (ifa.det)
  );

  mcr_edge_det u_det_b (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (portb_ext_irq_i),
    .ev        (ifb.det)
  );

  // register writes, reads, status and derived outputs
  always_comb begin
    logic [1:0] clr;
    logic [7:0] keep;
    clr = MCR_IRQ_ZERO;
    keep = 8'h00;
    next_st = st;
    // slave-select pin passes three stages
    next_st.ss_sync = {st.ss_sync[1:0], ss_pin_i};
    if (st.ss_sync[2] == st.ss_sync[1]) begin
      next_st.ss_level = st.ss_sync[1];
    end
    if (wr_i) begin
      case (addr_i)
        MCR_ADDR_CONFIG: begin
          // masked cpu allows sense change, else keep old bits
          keep = cpu_irq_masked_i ? 8'h00 : MCR_SENSE_MASK;
          next_st.cfg = (wdata_i & ~keep) | (st.cfg & keep);
        end
        MCR_ADDR_IRQ_EN:  next_st.en = wdata_i[1:0];
        MCR_ADDR_IRQ_CLR: clr = wdata_i[1:0];
        default: ;
      endcase
    end
    // set beats clear in the same cycle
    next_st.stat = (st.stat & ~clr) | {ifb.req, ifa.req};
    next_st.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        MCR_ADDR_CONFIG:   next_st.rdata = st.cfg;
        MCR_ADDR_IRQ_STAT: next_st.rdata = {6'h00, st.stat};
        MCR_ADDR_IRQ_EN:   next_st.rdata = {6'h00, st.en};
        default:           next_st.rdata = 8'h00;
      endcase
    end
    // divide ratios for the clock generators downstream
    next_st.pdiv = next_st.cfg[MCR_BIT_PERIPH_DIV] ?
                   6'(MCR_PERIPH_DIV_SLOW) : 6'(MCR_PERIPH_DIV_NORMAL);
    next_st.cdiv = next_st.cfg[MCR_BIT_SLOW_CPU] ?
                   6'(MCR_CPU_DIV_SLOW) : 6'(MCR_CPU_DIV_NORMAL);
    // soft level frees the pin for general use
    next_st.ss_out = next_st.cfg[MCR_BIT_SS_SOURCE] ?
                     next_st.cfg[MCR_BIT_SS_SOFT] :
                     next_st.ss_level;
    next_st.reqa = ifa.req;
    next_st.reqb = ifb.req;
    next_st.irq = |(next_st.stat & next_st.en);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '{cfg: MCR_CONFIG_RESET, stat: MCR_IRQ_ZERO, en: MCR_IRQ_ZERO,
              rdata: 8'h00, ss_sync: 3'h7, ss_level: 1'b1,
              pdiv: 6'(MCR_PERIPH_DIV_NORMAL),
              cdiv: 6'(MCR_CPU_DIV_NORMAL),
              ss_out: 1'b1, reqa: 1'b0, reqb: 1'b0, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o            = st.rdata;
  assign periph_clock_div_o = st.pdiv;
  assign cpu_clock_div_o    = st.cdiv;
  assign spi_ss_level_o     = st.ss_out;
  assign porta_ext_irq_o    = st.reqa;
  assign portb_ext_irq_o    = st.reqb;
  assign irq_o              = st.irq;

  // checks
  AST_DIV_PERIPH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    periph_clock_div_o == (st.cfg[MCR_BIT_PERIPH_DIV] ? 6'h04 : 6'h02))
    else $error("peripheral divide mismatch");
  AST_DIV_CPU: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cpu_clock_div_o == (st.cfg[MCR_BIT_SLOW_CPU] ? 6'h20 : 6'h02))
    else $error("cpu divide mismatch");
  AST_SS_SOFT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st.cfg[MCR_BIT_SS_SOURCE] |-> spi_ss_level_o == st.cfg[MCR_BIT_SS_SOFT])
    else $error("soft slave select wrong");
  AST_SS_PIN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !st.cfg[MCR_BIT_SS_SOURCE] |-> spi_ss_level_o == st.ss_level)
    else $error("pin slave select wrong");
  AST_SENSE_LOCK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == MCR_ADDR_CONFIG && !cpu_irq_masked_i) |=>
    (st.cfg & MCR_SENSE_MASK) == ($past(st.cfg) & MCR_SENSE_MASK))
    else $error("sense changed while unmasked");
  AST_WRITE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == MCR_ADDR_CONFIG && cpu_irq_masked_i) |=>
    st.cfg == $past(wdata_i))
    else $error("config write lost");
  AST_READ: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && addr_i == MCR_ADDR_CONFIG && !wr_i) ##1 1'b1 |->
    rdata_o == $past(st.cfg))
    else $error("config read wrong");
  AST_SENSE_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ifa.sense == st.cfg[2:1])
    else $error("port A sense wrong");
  AST_SENSE_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ifb.sense == st.cfg[4:3])
    else $error("port B sense wrong");
  AST_RISE_ONCE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ifa.sense == 2'h1 && ifa.req) |=> !ifa.req)
    else $error("double rising request");
  AST_IRQ: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    irq_o == |(st.stat & st.en))
    else $error("irq output wrong");

  // reset leaves the register and every output at its idle value
  AST_RESET_CFG: assert property (@(posedge ref_clk_i)
    rst_i |=> st.cfg == MCR_CONFIG_RESET)
    else $error("config not cleared by reset");
  AST_RESET_DIV: assert property (@(posedge ref_clk_i)
    rst_i |=> periph_clock_div_o == 6'(MCR_PERIPH_DIV_NORMAL) &&
              cpu_clock_div_o == 6'(MCR_CPU_DIV_NORMAL))
    else $error("divides not normal after reset");
  AST_RESET_OUT: assert property (@(posedge ref_clk_i)
    rst_i |=> rdata_o == 8'h00 && !irq_o && !porta_ext_irq_o &&
              !portb_ext_irq_o)
    else $error("outputs not idle after reset");
  AST_RESET_SS: assert property (@(posedge ref_clk_i)
    rst_i |=> spi_ss_level_o)
    else $error("slave select not idle after reset");

  // read port: data stand one cycle only, zero otherwise
  AST_RDATA_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero when idle");
  AST_READ_STAT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && addr_i == MCR_ADDR_IRQ_STAT) |=>
    rdata_o == {6'h00, $past(st.stat)})
    else $error("status read wrong");
  AST_READ_EN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && addr_i == MCR_ADDR_IRQ_EN) |=>
    rdata_o == {6'h00, $past(st.en)})
    else $error("enable read wrong");
  AST_READ_UNMAPPED: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    (rd_i && addr_i != MCR_ADDR_CONFIG && addr_i != MCR_ADDR_IRQ_STAT &&
     addr_i != MCR_ADDR_IRQ_EN) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // config write path: unmasked writes still reach the other fields
  AST_KEEP_OTHERS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == MCR_ADDR_CONFIG && !cpu_irq_masked_i) |=>
    (st.cfg & ~MCR_SENSE_MASK) == ($past(wdata_i) & ~MCR_SENSE_MASK))
    else $error("unmasked write lost other bits");
  AST_CFG_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!wr_i || addr_i != MCR_ADDR_CONFIG) |=> st.cfg == $past(st.cfg))
    else $error("config changed without a write");
  AST_SENSE_WR_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == MCR_ADDR_CONFIG && cpu_irq_masked_i) |=>
    ifa.sense == $past(wdata_i[MCR_BIT_PORTA_SENSE +: 2]))
    else $error("port A sense write lost");
  AST_SENSE_WR_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == MCR_ADDR_CONFIG && cpu_irq_masked_i) |=>
    ifb.sense == $past(wdata_i[MCR_BIT_PORTB_SENSE +: 2]))
    else $error("port B sense write lost");
  AST_DIV_STABLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !wr_i |=> $stable(periph_clock_div_o) && $stable(cpu_clock_div_o))
    else $error("divide moved without a write");

  // enable and status bookkeeping; a set in the clear cycle wins
  AST_EN_WRITE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == MCR_ADDR_IRQ_EN) |=> st.en == $past(wdata_i[1:0]))
    else $error("enable write lost");
  AST_STAT_SET_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ifa.req |=> st.stat[MCR_IRQ_PORTA])
    else $error("port A status not set");
  AST_STAT_SET_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ifb.req |=> st.stat[MCR_IRQ_PORTB])
    else $error("port B status not set");
  AST_SET_WINS_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ifa.req && wr_i && addr_i == MCR_ADDR_IRQ_CLR) |=>
    st.stat[MCR_IRQ_PORTA])
    else $error("clear beat port A set");
  AST_SET_WINS_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ifb.req && wr_i && addr_i == MCR_ADDR_IRQ_CLR) |=>
    st.stat[MCR_IRQ_PORTB])
    else $error("clear beat port B set");
  AST_STAT_CLR_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == MCR_ADDR_IRQ_CLR && wdata_i[MCR_IRQ_PORTA] &&
     !ifa.req) |=> !st.stat[MCR_IRQ_PORTA])
    else $error("port A status not cleared");
  AST_STAT_CLR_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == MCR_ADDR_IRQ_CLR && wdata_i[MCR_IRQ_PORTB] &&
     !ifb.req) |=> !st.stat[MCR_IRQ_PORTB])
    else $error("port B status not cleared");
  AST_STAT_HOLD_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.stat[MCR_IRQ_PORTA] && !(wr_i && addr_i == MCR_ADDR_IRQ_CLR &&
     wdata_i[MCR_IRQ_PORTA])) |=> st.stat[MCR_IRQ_PORTA])
    else $error("port A status lost");
  AST_STAT_HOLD_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.stat[MCR_IRQ_PORTB] && !(wr_i && addr_i == MCR_ADDR_IRQ_CLR &&
     wdata_i[MCR_IRQ_PORTB])) |=> st.stat[MCR_IRQ_PORTB])
    else $error("port B status lost");
  AST_STAT_RO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == MCR_ADDR_IRQ_STAT && !ifa.req && !ifb.req) |=>
    st.stat == $past(st.stat))
    else $error("status took a write");
  AST_IRQ_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st.en == MCR_IRQ_ZERO |-> !irq_o)
    else $error("irq raised while disabled");

  // request outputs mirror the detectors one cycle late
  AST_REQ_OUT_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    porta_ext_irq_o == $past(ifa.req))
    else $error("port A request output wrong");
  AST_REQ_OUT_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    portb_ext_irq_o == $past(ifb.req))
    else $error("port B request output wrong");

  // edge modes give a single-cycle pulse per settled transition
  AST_RISE_ONCE_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ifb.sense == MCR_SENSE_RISE && ifb.req) |=> !ifb.req)
    else $error("double port B rising request");
  AST_FALL_ONCE_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ifa.sense == MCR_SENSE_FALL && ifa.req) |=> !ifa.req)
    else $error("double port A falling request");
  AST_FALL_ONCE_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ifb.sense == MCR_SENSE_FALL && ifb.req) |=> !ifb.req)
    else $error("double port B falling request");
  AST_BOTH_ONCE_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ifa.sense == MCR_SENSE_BOTH && ifa.req) |=> !ifa.req)
    else $error("double port A edge request");
  AST_BOTH_ONCE_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ifb.sense == MCR_SENSE_BOTH && ifb.req) |=> !ifb.req)
    else $error("double port B edge request");

  // slave-select level only moves once two sync stages agree
  AST_SS_SETTLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.ss_sync[2] == st.ss_sync[1]) |=>
    st.ss_level == $past(st.ss_sync[1]))
    else $error("slave select level not settled");
  AST_SS_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.ss_sync[2] != st.ss_sync[1]) |=> $stable(st.ss_level))
    else $error("slave select level moved early");

  COV_WRITE_MASKED: cover property (@(posedge ref_clk_i)
    wr_i && addr_i == MCR_ADDR_CONFIG && cpu_irq_masked_i);
  COV_WRITE_UNMASKED: cover property (@(posedge ref_clk_i)
    wr_i && addr_i == MCR_ADDR_CONFIG && !cpu_irq_masked_i);
  COV_IRQ_A: cover property (@(posedge ref_clk_i) ifa.req);
  COV_IRQ_OUT: cover property (@(posedge ref_clk_i) irq_o);
  COV_SLOW_CPU: cover property (@(posedge ref_clk_i)
    cpu_clock_div_o == 6'(MCR_CPU_DIV_SLOW));

endmodule

// [include/mcr_pkg.sv]
// Purpose: shared constants and types for the miscellaneous config register
// Assumes: 8-bit register port, 100 MHz reference clock
// Notes:   interrupt status/enable/clear registers sit next to the config
package mcr_pkg;

  // register offsets
  localparam logic [7:0] MCR_ADDR_CONFIG   = 8'h20;
  localparam logic [7:0] MCR_ADDR_IRQ_STAT = 8'h21;
  localparam logic [7:0] MCR_ADDR_IRQ_EN   = 8'h22;
  localparam logic [7:0] MCR_ADDR_IRQ_CLR  = 8'h23;

  // field positions of misc_config
  localparam int MCR_BIT_PERIPH_DIV   = 7;
  localparam int MCR_BIT_SS_SOURCE    = 6;
  localparam int MCR_BIT_SS_SOFT      = 5;
  localparam int MCR_BIT_PORTB_SENSE  = 3;
  localparam int MCR_BIT_PORTA_SENSE  = 1;
  localparam int MCR_BIT_SLOW_CPU     = 0;

  // interrupt status bit positions
  localparam int MCR_IRQ_PORTA = 0;
  localparam int MCR_IRQ_PORTB = 1;

  localparam logic [7:0] MCR_CONFIG_RESET = 8'h00;
  localparam logic [7:0] MCR_SENSE_MASK   = 8'h1E;
  localparam logic [1:0] MCR_IRQ_ZERO     = 2'h0;

  // clock divide ratios
  localparam int MCR_PERIPH_DIV_NORMAL = 2;
  localparam int MCR_PERIPH_DIV_SLOW   = 4;
  localparam int MCR_CPU_DIV_NORMAL    = 2;
  localparam int MCR_CPU_DIV_SLOW      = 32;

  // sensitivity encodings
  typedef enum logic [1:0] {
    MCR_SENSE_FALL_LOW = 2'h0,
    MCR_SENSE_RISE     = 2'h1,
    MCR_SENSE_FALL     = 2'h2,
    MCR_SENSE_BOTH     = 2'h3
  } mcr_sense_t;

endpackage

// [include/mcr_edge_if.sv]
`timescale 1ns/1ps
// Purpose: carries one interrupt pin's sensitivity and request
// Assumes: single clock domain
// Notes:   none
interface mcr_edge_if;
  import mcr_pkg::*;
  logic [1:0] sense;
  logic       req;
  modport det (input sense, output req);
  modport top (output sense, input req);
endinterface

// [core/mcr_edge_det.sv]
`timescale 1ns/1ps
// Purpose: synchronise one external interrupt pin and detect its event
// Assumes: pin is asynchronous to ref_clk_i
// Notes:   req is a one-cycle pulse, or a level for falling-edge-and-low
module mcr_edge_det
  import mcr_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // pin and link to top
  input  wire logic pin_i,
  mcr_edge_if.det   ev
);

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
    logic       req;
  } mcr_det_state_t;

  mcr_det_state_t st;
  mcr_det_state_t next_st;

  // the level only moves once the second and third stages agree
  always_comb begin
    logic fall;
    logic rise;
    fall = 1'b0;
    rise = 1'b0;
    next_st = st;
    next_st.sync = {st.sync[1:0], pin_i};
    if (st.sync[2] == st.sync[1] && st.sync[1] != st.level) begin
      next_st.level = st.sync[1];
      fall = ~st.sync[1];
      rise = st.sync[1];
    end
    // one transition gives one request in the edge senses; falling-edge-and-low also holds it while low
    case (mcr_sense_t'(ev.sense))
      MCR_SENSE_FALL_LOW: next_st.req = fall | ~next_st.level;
      MCR_SENSE_RISE:     next_st.req = rise;
      MCR_SENSE_FALL:     next_st.req = fall;
      MCR_SENSE_BOTH:     next_st.req = rise | fall;
      default:            next_st.req = 1'b0;
    endcase
  end

  // idle level is high so reset does not fake a falling edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '{sync: 3'h7, level: 1'b1, req: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ev.req = st.req;

endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
// Purpose: self-checking bench for the misc config register
// Assumes: one-cycle strobes, read data in the cycle after the strobe
// Notes:   pins pass a 3-flop sync, so checks wait several cycles
module tb_top
  import mcr_pkg::*;
;
  logic       ref_clk_i, rst_i, wr_i, rd_i, masked, pa, pb, ss;
  logic [7:0] addr_i, wdata_i, rdata_o, cfg, v, d;
  logic [5:0] pdiv, cdiv;
  logic       ss_lvl, pa_o, pb_o, irq_o;
  logic [31:0] seed = 32'h47;
  int         bad_count, n_compared, cnt[2];

  mcr_misc_config dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cpu_irq_masked_i(masked), .porta_ext_irq_i(pa),
    .portb_ext_irq_i(pb), .ss_pin_i(ss), .periph_clock_div_o(pdiv),
    .cpu_clock_div_o(cdiv), .spi_ss_level_o(ss_lvl),
    .porta_ext_irq_o(pa_o), .portb_ext_irq_o(pb_o), .irq_o(irq_o));

  // free-running 100 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // count request cycles per port; a sensed edge in an edge mode must give exactly one
  always @(posedge ref_clk_i) begin
    if (pa_o === 1'b1) cnt[0]++;
    if (pb_o === 1'b1) cnt[1]++;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // sense bits keep their old value unless the cpu mask flag is set
  function automatic logic [7:0] exp_cfg(logic [7:0] o, n, logic m);
    return m ? n : (n & ~MCR_SENSE_MASK) | (o & MCR_SENSE_MASK);
  endfunction

  function automatic logic [7:0] div(logic s, int a, int b);
    return s ? 8'(b) : 8'(a);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= x;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 x = rdata_o;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: the tests need well under 20000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    summarize();
  end

  // main sequence
  initial begin
    {rst_i, masked, pa, pb, ss} = 5'h1F;
    {wr_i, rd_i, addr_i, wdata_i} = 18'h0;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(MCR_ADDR_CONFIG, d);
    chk(d, 8'h00);
    chk({2'h0, pdiv}, 8'h02);
    chk({2'h0, cdiv}, 8'h02);
    $display("reset values done");
    cfg = 8'h00;
    for (int i = 0; i < 16; i++) begin
      v = (i < 2) ? 8'hFF : rnd();
      @(posedge ref_clk_i);
      masked <= i[0];
      wr(MCR_ADDR_CONFIG, v);
      cfg = exp_cfg(cfg, v, i[0]);
      rd(MCR_ADDR_CONFIG, d);
      chk(d, cfg);
      chk({2'h0, pdiv}, div(cfg[7], 2, 4));
      chk({2'h0, cdiv}, div(cfg[0], 2, 32));
    end
    $display("random writes done");
    masked <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      @(posedge ref_clk_i);
      ss <= v[0];
      wr(MCR_ADDR_CONFIG, {1'b0, v[1], v[2], 5'h0});
      repeat (6) @(posedge ref_clk_i);
      #1 chk({7'h0, ss_lvl}, {7'h0, v[1] ? v[2] : v[0]});
    end
    $display("slave select done");
    wr(MCR_ADDR_IRQ_EN, 8'h03);
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr(MCR_ADDR_CONFIG, 8'(m) << (p ? 3 : 1));
        repeat (6) @(posedge ref_clk_i);
        wr(MCR_ADDR_IRQ_CLR, 8'h03);
        #1 cnt[p] = 0;
        @(posedge ref_clk_i);
        if (p == 0) pa <= 1'b0; else pb <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        #1 chk(m == 0 ? 8'(cnt[p] != 0) : 8'(cnt[p]),
               8'(m != 1));
        chk({7'h0, irq_o}, 8'(m != 1));
        rd(MCR_ADDR_IRQ_STAT, d);
        chk(d, (m != 1) ? 8'(1 << p) : 8'h00);
        cnt[p] = 0;
        @(posedge ref_clk_i);
        if (p == 0) pa <= 1'b1; else pb <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        if (m != 0) #1 chk(8'(cnt[p]), 8'(m[0]));
        wr(MCR_ADDR_IRQ_CLR, 8'h03);
        rd(MCR_ADDR_IRQ_STAT, d);
        chk(d, 8'h00);
        chk({7'h0, irq_o}, 8'h00);
      end
    end
    $display("sensitivity modes done");
    wr(MCR_ADDR_IRQ_STAT, 8'hFF);
    rd(MCR_ADDR_IRQ_STAT, d);
    chk(d, 8'h00);
    rd(8'h7F, d);
    chk(d, 8'h00);
    $display("unmapped access done");
    summarize();
  end
endmodule
